//--- rtl/isf_pkg.sv
// Shared constants and carrier types for the bus status and flag logic
package isf_pkg;
    // Flag register location on the peripheral map
    localparam logic [19:0] FLAG_REG_ADDR = 20'hfff52;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Status register bit positions
    localparam int ST_MASTER = 7;
    localparam int ST_ARB = 6;
    localparam int ST_EXT = 5;
    localparam int ST_MATCH = 4;
    localparam int ST_TX = 3;
    localparam int ST_ACK = 2;
    localparam int ST_START = 1;
    localparam int ST_STOP = 0;
    // Flag register bit positions
    localparam int FL_FAIL = 7;
    localparam int FL_BUSY = 6;
    localparam int FL_INIT = 1;
    localparam int FL_RSV = 0;
    // Extension code patterns in the upper address nibble
    localparam logic [3:0] EXT_LOW = 4'h0;
    localparam logic [3:0] EXT_HIGH = 4'hf;
    // Serial clock counts, zero based
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_EIGHTH = 4'h7;
    localparam logic [3:0] BIT_NINTH = 4'h8;
    // Events crossing from the link domain
    localparam int EVT_N = 5;
    localparam int EV_START = 0;
    localparam int EV_STOP = 1;
    localparam int EV_RISE1 = 2;
    localparam int EV_RISE8 = 3;
    localparam int EV_RISE9 = 4;

    typedef struct packed {
        logic unit_enable;
        logic leave_communication;
        logic wait_release;
        logic start_trigger_set;
        logic status_read;
        logic bit_instr_other;
    } isf_ctl_s;

    typedef struct packed {
        logic start_generated;
        logic arb_lost;
        logic shift_out_latch;
    } isf_dp_s;

    typedef struct packed {
        logic master_active_flag;
        logic arb_lost_flag;
        logic ext_code_flag;
        logic addr_match_flag;
        logic transmit_state_flag;
        logic ack_seen_flag;
        logic start_seen_flag;
        logic stop_seen_flag;
    } isf_status_s;

    typedef struct packed {
        logic start_fail_flag;
        logic bus_busy_flag;
        logic initial_start_allow;
        logic reservation_disable;
    } isf_flag_s;

    typedef struct packed {
        isf_status_s st;
        isf_flag_s fl;
        logic en;
        logic addr_done;
        logic start_pend;
        logic [EVT_N-1:0] s1;
        logic [EVT_N-1:0] s2;
        logic [EVT_N-1:0] s3;
        logic [EVT_N-1:0] seen;
    } isf_sys_s;

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic scl_f;
        logic sda_f;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] addr;
        logic ack;
        logic [EVT_N-1:0] tog;
    } isf_link_s;
endpackage

//--- rtl/isf_status_flags.sv
// Status and flag logic of the two-wire serial bus unit
`timescale 1ns/1ps

// How it works
// - Master flag set on generated start, cleared on stop, loss, leave or disable
// - Zero master flag means slave or standby
// - Arbitration loss sets lost, clears master
// - Status read or bit instruction clears lost
// - Eighth rise sets extension flag on 0000/1111
// - Eighth rise sets match on own address
// - Transmit flag lets latch drive data line
// - Transmit set on start or direction bit
// - Transmit cleared on stop, leave, idle, etc
// - Transmit cleared by opposite direction, slave start
// - Wait release while transmitting floats data line
// - Ack flag on low data at ninth rise
// - Start flag marks address phase
// - Stop flag held until next address byte
// - Fail and busy read-only; writes need disable
// - Reset clears whole flag register
// - Refused start clears trigger, sets fail
// - Busy set on start or early enable
// - Initial start bit skips stop wait
// - Reservation holds start until bus free
module isf_status_flags
    import isf_pkg::*;
(
    // Clocks and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_lk_clk,
    // Serial pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // Software and datapath controls
    input wire isf_ctl_s i_ctl,
    input wire isf_dp_s i_dp,
    input wire logic [6:0] i_own_addr,
    input wire logic i_flag_wr,
    input wire logic [7:0] i_flag_wdata,
    // Register reads and start handshake
    output logic [7:0] o_status_reg,
    output logic [7:0] o_flag_reg,
    output logic o_start_go,
    output logic o_start_trig_clr
);

    isf_sys_s q, d;
    isf_link_s lq, ld;
    logic [EVT_N-1:0] ev;
    logic kill;
    logic refuse;

    function automatic logic filt(input logic s2, input logic s3,
                                  input logic old);
        filt = (s2 == s3) ? s3 : old;
    endfunction

    function automatic logic is_ext(input logic [7:0] a);
        is_ext = (a[7:4] == EXT_LOW) || (a[7:4] == EXT_HIGH);
    endfunction

    // Link domain: pin filtering, condition detection and bit counting
    always_comb begin
        ld = lq;
        ld.scl_sync = {lq.scl_sync[1:0], i_scl};
        ld.sda_sync = {lq.sda_sync[1:0], i_sda};
        ld.scl_f = filt(lq.scl_sync[1], lq.scl_sync[2], lq.scl_f);
        ld.sda_f = filt(lq.sda_sync[1], lq.sda_sync[2], lq.sda_f);
        if (lq.scl_f && ld.scl_f && lq.sda_f && !ld.sda_f) begin
            ld.cnt = BIT_FIRST;
            ld.tog[EV_START] = ~lq.tog[EV_START];
        end else if (lq.scl_f && ld.scl_f && !lq.sda_f && ld.sda_f) begin
            ld.cnt = BIT_FIRST;
            ld.tog[EV_STOP] = ~lq.tog[EV_STOP];
        end else if (!lq.scl_f && ld.scl_f) begin
            ld.shreg = {lq.shreg[6:0], ld.sda_f};
            if (lq.cnt == BIT_FIRST) begin
                ld.tog[EV_RISE1] = ~lq.tog[EV_RISE1];
            end
            if (lq.cnt == BIT_EIGHTH) begin
                // Byte is captured with the eighth-rise toggle and stays stable until the next eighth rise
                ld.addr = {lq.shreg[6:0], ld.sda_f};
                ld.tog[EV_RISE8] = ~lq.tog[EV_RISE8];
            end
            if (lq.cnt == BIT_NINTH) begin
                ld.ack = ~ld.sda_f;
                ld.tog[EV_RISE9] = ~lq.tog[EV_RISE9];
                ld.cnt = BIT_FIRST;
            end else begin
                ld.cnt = lq.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge i_lk_clk or posedge i_rst) begin
        if (i_rst) begin
            // Lines idle high, so no false edge follows reset
            lq <= '0;
            lq.scl_sync <= '1;
            lq.sda_sync <= '1;
            lq.scl_f <= 1'b1;
            lq.sda_f <= 1'b1;
        end else begin
            lq <= ld;
        end
    end

    // Toggle crossing: an event counts once the second and third agree
    always_comb begin
        for (int i = 0; i < EVT_N; i++) begin
            ev[i] = (q.s2[i] == q.s3[i]) && (q.s3[i] != q.seen[i]);
        end
    end

    assign kill = !i_ctl.unit_enable;
    assign refuse = i_ctl.start_trigger_set && q.fl.bus_busy_flag
        && q.fl.reservation_disable && i_ctl.unit_enable;

    // System domain: status and flag registers
    always_comb begin
        d = q;
        d.s1 = lq.tog;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < EVT_N; i++) begin
            if (ev[i]) begin
                d.seen[i] = q.s3[i];
            end
        end
        d.en = i_ctl.unit_enable;

        // Master ownership
        if (ev[EV_STOP] || i_dp.arb_lost || i_ctl.leave_communication) begin
            d.st.master_active_flag = 1'b0;
        end
        if (i_dp.start_generated) begin
            d.st.master_active_flag = 1'b1;
        end

        // Arbitration loss; a new loss beats a read clear
        if (i_ctl.status_read || i_ctl.bit_instr_other) begin
            d.st.arb_lost_flag = 1'b0;
        end
        if (i_dp.arb_lost) begin
            d.st.arb_lost_flag = 1'b1;
            d.st.master_active_flag = 1'b0;
        end

        // Address phase results
        if (ev[EV_START] || ev[EV_STOP] || i_ctl.leave_communication) begin
            d.st.ext_code_flag = 1'b0;
            d.st.addr_match_flag = 1'b0;
        end
        if (ev[EV_RISE8] && q.st.start_seen_flag) begin
            if (is_ext(lq.addr)) begin
                d.st.ext_code_flag = 1'b1;
            end
            if (lq.addr[7:1] == i_own_addr) begin
                d.st.addr_match_flag = 1'b1;
            end
        end

        // Acknowledge
        if (ev[EV_STOP] || ev[EV_RISE1] || i_ctl.leave_communication) begin
            d.st.ack_seen_flag = 1'b0;
        end
        if (ev[EV_RISE9]) begin
            d.st.ack_seen_flag = lq.ack;
        end

        // Start and stop conditions
        if (ev[EV_RISE9] && q.st.start_seen_flag) begin
            d.addr_done = 1'b1;
        end
        if (ev[EV_RISE1] && q.addr_done) begin
            d.st.start_seen_flag = 1'b0;
            d.addr_done = 1'b0;
        end
        if (ev[EV_RISE1] && q.st.start_seen_flag && !q.addr_done) begin
            d.st.stop_seen_flag = 1'b0;
        end
        if (ev[EV_STOP] || i_ctl.leave_communication) begin
            d.st.start_seen_flag = 1'b0;
            d.addr_done = 1'b0;
        end
        if (ev[EV_START]) begin
            d.st.start_seen_flag = 1'b1;
            d.addr_done = 1'b0;
        end
        if (ev[EV_STOP]) begin
            d.st.stop_seen_flag = 1'b1;
        end

        // Transmit direction
        if (ev[EV_STOP] || i_ctl.leave_communication
            || i_ctl.wait_release || i_dp.arb_lost) begin
            d.st.transmit_state_flag = 1'b0;
        end
        if (ev[EV_START] && !q.st.master_active_flag) begin
            d.st.transmit_state_flag = 1'b0;
        end
        if (ev[EV_RISE8] && q.st.start_seen_flag) begin
            if (q.st.master_active_flag) begin
                d.st.transmit_state_flag = ~lq.addr[0];
            end else if (d.st.addr_match_flag || d.st.ext_code_flag) begin
                d.st.transmit_state_flag = lq.addr[0];
            end
        end
        if (i_dp.start_generated) begin
            d.st.transmit_state_flag = 1'b1;
        end
        if (!d.st.master_active_flag && !d.st.ext_code_flag
            && !d.st.addr_match_flag) begin
            d.st.transmit_state_flag = 1'b0;
        end

        // Flag register; only mode bits are writable, and only when stopped
        if (i_flag_wr && kill) begin
            d.fl.initial_start_allow = i_flag_wdata[FL_INIT];
            d.fl.reservation_disable = i_flag_wdata[FL_RSV];
        end
        if (ev[EV_START] && i_ctl.unit_enable) begin
            d.fl.initial_start_allow = 1'b0;
        end
        if (ev[EV_STOP]) begin
            d.fl.bus_busy_flag = 1'b0;
        end
        if (ev[EV_START]) begin
            d.fl.bus_busy_flag = 1'b1;
        end
        if (i_ctl.unit_enable && !q.en && !q.fl.initial_start_allow) begin
            d.fl.bus_busy_flag = 1'b1;
        end
        if (i_ctl.start_trigger_set) begin
            d.fl.start_fail_flag = refuse;
        end

        // Reservation: a start asked for on a busy bus waits for release
        if (i_dp.start_generated || i_dp.arb_lost
            || i_ctl.leave_communication || refuse) begin
            d.start_pend = 1'b0;
        end
        if (i_ctl.start_trigger_set && !refuse) begin
            d.start_pend = 1'b1;
        end

        // Stopping the unit clears all live state; mode bits survive
        if (kill) begin
            d.st = '0;
            d.fl.bus_busy_flag = 1'b0;
            d.fl.start_fail_flag = 1'b0;
            d.start_pend = 1'b0;
            d.addr_done = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs
    always_comb begin
        o_status_reg = q.st;
        o_flag_reg = REG_RESET;
        o_flag_reg[FL_FAIL] = q.fl.start_fail_flag;
        o_flag_reg[FL_BUSY] = q.fl.bus_busy_flag;
        o_flag_reg[FL_INIT] = q.fl.initial_start_allow;
        o_flag_reg[FL_RSV] = q.fl.reservation_disable;
    end

    // Open drain: only a low is ever driven, and only while transmitting
    assign o_sda_o = 1'b0;
    assign o_sda_oe = q.st.transmit_state_flag
        && !i_dp.shift_out_latch;
    assign o_start_go = q.start_pend && !q.fl.bus_busy_flag;
    assign o_start_trig_clr = refuse;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    sequence addr_ext_s;
        ev[EV_RISE8] && q.st.start_seen_flag && is_ext(lq.addr)
            && i_ctl.unit_enable;
    endsequence

    sequence quiet_s;
        !ev[EV_START] && !ev[EV_STOP] && !i_ctl.leave_communication;
    endsequence

    sequence addr_own_s;
        ev[EV_RISE8] && q.st.start_seen_flag
            && (lq.addr[7:1] == i_own_addr) && i_ctl.unit_enable;
    endsequence

    arb_clears_master_a: assert property (
        i_dp.arb_lost && i_ctl.unit_enable
        |=> q.st.arb_lost_flag && !q.st.master_active_flag)
        else $error("arbitration loss left master flag set");

    read_clears_arb_a: assert property (
        q.st.arb_lost_flag && i_ctl.status_read && !i_dp.arb_lost
        |=> !q.st.arb_lost_flag)
        else $error("lost flag survived a status read");

    ext_code_set_a: assert property (
        (addr_ext_s and quiet_s) |=> q.st.ext_code_flag)
        else $error("extension code not flagged");

    sda_drive_a: assert property (
        o_sda_oe |-> q.st.transmit_state_flag && !o_sda_o)
        else $error("data line driven outside transmit state");

    tx_idle_clear_a: assert property (
        q.st.transmit_state_flag |-> q.st.master_active_flag
        || q.st.ext_code_flag || q.st.addr_match_flag)
        else $error("transmit flag set while not communicating");

    mode_bits_lock_a: assert property (
        i_ctl.unit_enable && i_flag_wr && !ev[EV_START]
        |=> $stable(q.fl.reservation_disable)
        && $stable(q.fl.initial_start_allow))
        else $error("mode bits written while enabled");

    start_fail_set_a: assert property (
        refuse |-> o_start_trig_clr ##1 q.fl.start_fail_flag
        && !q.start_pend)
        else $error("refused start not flagged");

    disable_clear_a: assert property (
        !i_ctl.unit_enable |=> q.st == '0 && !q.fl.bus_busy_flag
        && !q.fl.start_fail_flag)
        else $error("disable did not clear the flags");

    stop_frees_bus_a: assert property (
        ev[EV_STOP] && !ev[EV_START] && i_ctl.unit_enable
        |=> !q.fl.bus_busy_flag && q.st.stop_seen_flag)
        else $error("stop did not free the bus");

    reserve_hold_a: assert property (
        i_ctl.start_trigger_set && !refuse && i_ctl.unit_enable
        ##1 q.fl.bus_busy_flag |-> !o_start_go && q.start_pend)
        else $error("reserved start not held on busy bus");

    addr_match_set_a: assert property (
        (addr_own_s and quiet_s) |=> q.st.addr_match_flag)
        else $error("own address not flagged");

    master_set_a: assert property (
        i_dp.start_generated && !i_dp.arb_lost && i_ctl.unit_enable
        |=> q.st.master_active_flag)
        else $error("generated start did not set master flag");

    ack_seen_set_a: assert property (
        ev[EV_RISE9] && lq.ack && i_ctl.unit_enable
        |=> q.st.ack_seen_flag)
        else $error("acknowledge not flagged at ninth rise");

    start_seen_set_a: assert property (
        ev[EV_START] && i_ctl.unit_enable
        |=> q.st.start_seen_flag && q.fl.bus_busy_flag)
        else $error("start condition not flagged");

    init_start_clr_a: assert property (
        ev[EV_START] && i_ctl.unit_enable
        |=> !q.fl.initial_start_allow)
        else $error("initial start bit survived a start");

    stop_flag_hold_a: assert property (
        q.st.stop_seen_flag && !ev[EV_RISE1] && i_ctl.unit_enable
        |=> q.st.stop_seen_flag)
        else $error("stop flag cleared outside an address byte");

    wait_rel_float_a: assert property (
        i_ctl.wait_release && !i_dp.start_generated && !ev[EV_RISE8]
        |=> !q.st.transmit_state_flag && !o_sda_oe)
        else $error("wait release left the data line driven");

endmodule // isf_status_flags

//--- verif/isf_bus_model.sv
// Behavioural bus master on the far side of the serial pins
`timescale 1ns/1ps
module isf_bus_model (
    // Link clock
    input wire logic i_lk_clk,
    // Pull-low requests on the open-drain lines
    output logic o_scl_pull,
    output logic o_sda_pull
);
    // Lines released at time zero, so the pull-ups hold them high
    initial begin
        o_scl_pull = 1'b0;
        o_sda_pull = 1'b0;
    end
    // Long phases so the three-stage filter sees every level settle
    task automatic hold();
        repeat (6) @(posedge i_lk_clk);
    endtask
    task automatic start_cond();
        o_sda_pull <= 1'b1;
        hold();
        o_scl_pull <= 1'b1;
        hold();
    endtask
    // Data changes only while the clock line is low
    task automatic one_bit(input logic b);
        o_sda_pull <= ~b;
        hold();
        o_scl_pull <= 1'b0;
        hold();
        o_scl_pull <= 1'b1;
        hold();
    endtask
    // Eight bits msb first, then the ninth bit, low meaning acknowledge
    task automatic byte9(input logic [8:0] v);
        for (int i = 8; i >= 0; i--) begin
            one_bit(v[i]);
        end
    endtask
    // Clock stands high after the stop, both lines released
    task automatic stop_cond();
        o_sda_pull <= 1'b1;
        hold();
        o_scl_pull <= 1'b0;
        hold();
        o_sda_pull <= 1'b0;
        hold();
    endtask
endmodule // isf_bus_model

//--- verif/tb_top.sv
// Self-checking bench for the bus status and flag logic
`timescale 1ns/1ps
module tb_top;
    import isf_pkg::*;
    logic clk = 1'b0;
    logic lk = 1'b0;
    logic rst = 1'b1;
    logic fwr = 1'b0;
    logic [7:0] fwd = 8'h00;
    isf_ctl_s ctl = '0;
    isf_dp_s dp = 3'h1;
    logic [6:0] own = 7'h20;
    logic [7:0] st;
    logic [7:0] fl;
    logic sda_o;
    logic oe;
    logic go;
    logic tclr;
    logic spl;
    logic dpl;
    wire logic scl = ~spl;
    wire logic sda = ~(dpl | oe);
    int errors = 0;
    int check_count = 0;
    int seed = 32'h1df5eb27;

    initial begin
        forever #20 clk = ~clk;
    end
    // Odd start offset keeps the link clock out of phase with the system
    initial begin
        #7;
        forever #32 lk = ~lk;
    end

    isf_status_flags dut (
        .i_sys_clk(clk), .i_rst(rst), .i_lk_clk(lk),
        .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(oe),
        .i_ctl(ctl), .i_dp(dp), .i_own_addr(own),
        .i_flag_wr(fwr), .i_flag_wdata(fwd),
        .o_status_reg(st), .o_flag_reg(fl),
        .o_start_go(go), .o_start_trig_clr(tclr)
    );
    isf_bus_model pm (.i_lk_clk(lk), .o_scl_pull(spl), .o_sda_pull(dpl));

    task automatic close_out();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %0t reg %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_bit(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %0t bit %b expected %b", $time, g, e);
        end
    endtask
    task automatic chk(input logic [7:0] es, input logic [7:0] ef);
        cmp_reg(st, es);
        cmp_reg(fl, ef);
    endtask
    // Control pulses last one cycle; unit_enable is never in the mask
    task automatic pulse_ctl(input logic [5:0] m);
        @(negedge clk);
        ctl = ctl | m;
        @(negedge clk);
        ctl = ctl & ~m;
    endtask
    task automatic pulse_dp(input logic [2:0] m);
        @(negedge clk);
        dp = dp | m;
        @(negedge clk);
        dp = dp & ~m;
    endtask
    task automatic wr_flag(input logic [7:0] v);
        @(negedge clk);
        fwr = 1'b1;
        fwd = v;
        @(negedge clk);
        fwr = 1'b0;
    endtask
    task automatic en(input logic b);
        @(negedge clk);
        ctl.unit_enable = b;
        @(negedge clk);
    endtask
    // Link events need a few link plus system cycles to reach the flags
    task automatic settle();
        repeat (16) @(negedge clk);
    endtask

    initial begin
        #2000000;
        errors++;
        close_out();
    end

    initial begin
        own = 7'h20 | 7'($random(seed) & 7'h1f);
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk(8'h00, 8'h00);
        wr_flag(8'hff);
        chk(8'h00, 8'h03);
        en(1'b1);
        chk(8'h00, 8'h03);
        wr_flag(8'h00);
        chk(8'h00, 8'h03);
        // Master start, then leave, then arbitration loss twice
        pulse_ctl(6'h04);
        cmp_bit(go, 1'b1);
        pulse_dp(3'h4);
        chk(8'h88, 8'h03);
        cmp_bit(go, 1'b0);
        pulse_ctl(6'h10);
        chk(8'h00, 8'h03);
        pulse_ctl(6'h04);
        pulse_dp(3'h4);
        pulse_dp(3'h2);
        chk(8'h40, 8'h03);
        pulse_ctl(6'h01);
        chk(8'h00, 8'h03);
        pulse_dp(3'h2);
        pulse_ctl(6'h02);
        chk(8'h00, 8'h03);
        // Addressed as slave with a read request
        pm.start_cond();
        settle();
        chk(8'h02, 8'h41);
        pm.byte9({own, 1'b1, 1'b0});
        settle();
        chk(8'h1e, 8'h41);
        @(negedge clk);
        dp.shift_out_latch = 1'b0;
        #1 cmp_bit(oe, 1'b1);
        cmp_bit(sda_o, 1'b0);
        pulse_ctl(6'h08);
        chk(8'h16, 8'h41);
        cmp_bit(oe, 1'b0);
        dp.shift_out_latch = 1'b1;
        pm.one_bit(1'b1);
        settle();
        chk(8'h10, 8'h41);
        pm.stop_cond();
        settle();
        chk(8'h01, 8'h01);
        // Both extension patterns in the upper nibble
        for (int k = 0; k < 2; k++) begin
            pm.start_cond();
            settle();
            chk(8'h03, 8'h41);
            pm.byte9({(k == 0) ? 8'hf0 : 8'h0e, 1'b1});
            settle();
            chk(8'h22, 8'h41);
            pm.stop_cond();
            settle();
            chk(8'h01, 8'h01);
        end
        // Reservation holds a start while another party owns the bus
        en(1'b0);
        wr_flag(8'h00);
        en(1'b1);
        chk(8'h00, 8'h40);
        @(negedge clk);
        ctl.start_trigger_set = 1'b1;
        #1 cmp_bit(tclr, 1'b0);
        @(negedge clk);
        ctl.start_trigger_set = 1'b0;
        cmp_bit(go, 1'b0);
        pm.start_cond();
        pm.stop_cond();
        settle();
        cmp_bit(go, 1'b1);
        chk(8'h01, 8'h00);
        // Reservation off: a start on a busy bus is refused
        en(1'b0);
        chk(8'h00, 8'h00);
        wr_flag(8'h01);
        en(1'b1);
        chk(8'h00, 8'h41);
        @(negedge clk);
        ctl.start_trigger_set = 1'b1;
        #1 cmp_bit(tclr, 1'b1);
        @(negedge clk);
        ctl.start_trigger_set = 1'b0;
        chk(8'h00, 8'hc1);
        en(1'b0);
        chk(8'h00, 8'h01);
        close_out();
    end
endmodule // tb_top
